// ==== logic/cmpir_consts.svh ====
// Register offsets, field positions and reset values of the comparator interrupt bank
`ifndef CMPIR_CONSTS_SVH
`define CMPIR_CONSTS_SVH
`define CMPIR_OFS_IRQ_DIRECT  12'h300
`define CMPIR_OFS_IRQ_SET     12'h304
`define CMPIR_OFS_IRQ_CLEAR   12'h308
`define CMPIR_OFS_RESULT      12'h400
`define CMPIR_OFS_ENABLE      12'h500
`define CMPIR_OFS_EVT_STATUS  12'h600
`define CMPIR_OFS_TASK        12'h604
`define CMPIR_BIT_READY       0
`define CMPIR_BIT_DOWN        1
`define CMPIR_BIT_UP          2
`define CMPIR_BIT_CROSS       3
`define CMPIR_BIT_TASK_SAMPLE 0
`define CMPIR_BIT_TASK_START  1
`define CMPIR_BIT_TASK_STOP   2
`define CMPIR_RST_IRQ         4'h0
`define CMPIR_RST_RESULT      1'b0
`define CMPIR_RST_ENABLE      2'h0
`define CMPIR_READY_CYCLES    8'h4B
`endif

// ==== logic/cmpir_edge.sv ====
// Edge detector that turns comparator output changes into event pulses
`timescale 1ns/1ns
`include "cmpir_consts.svh"
module cmpir_edge
  import cmpir_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       running,
  input  wire logic       compOut,
  output      cmpir_evt_t evtPulse
);
  logic prevOut_q;
  logic primed_q;
  wire  goDown = running && primed_q && prevOut_q && !compOut;
  wire  goUp   = running && primed_q && !prevOut_q && compOut;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      prevOut_q <= 1'b0;
      primed_q  <= 1'b0;
    end else begin
      prevOut_q <= compOut;
      primed_q  <= running;
    end
  end

  assign evtPulse[`CMPIR_BIT_READY] = 1'b0;
  assign evtPulse[`CMPIR_BIT_DOWN]  = goDown;
  assign evtPulse[`CMPIR_BIT_UP]    = goUp;
  assign evtPulse[`CMPIR_BIT_CROSS] = goDown || goUp;
endmodule : cmpir_edge

// ==== logic/cmpir_pkg.sv ====
// Types shared by the comparator interrupt bank
package cmpir_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cmpir_bus_s;

  typedef logic [3:0] cmpir_evt_t;

  typedef enum logic [1:0] {
    CMPIR_IDLE,
    CMPIR_START,
    CMPIR_RUN
  } cmpir_state_e;
endpackage : cmpir_pkg

// ==== logic/cmpir_regs.sv ====
// Comparator interrupt enable, event status and result register bank
// Operation
// - Set bit 0 enables ready interrupt
// - Set bit 1 enables downward interrupt
// - Set bit 2 enables upward interrupt
// - Set bit 3 enables crossing interrupt
// - Clear bit 0 disables ready interrupt
// - Clear bit 1 disables downward interrupt
// - Clear bit 2 disables upward interrupt
// - Clear bit 3 disables crossing interrupt
// - Result read-only, captured on sample; the code captures it only in the RUN state
// - Result zero when positive input below
// - Result one when positive input above
// - Crossing event on any output change; the code flags it only in the RUN state, and not in the first RUN cycle
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "cmpir_consts.svh"
module cmpir_regs
  import cmpir_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output      logic [31:0] rdata,
  input  wire logic        compOut,
  input  wire logic        sampleTrig,
  output      logic        compPowered,
  output      logic        irq
);
  cmpir_bus_s   bus;
  cmpir_state_e state_q;
  cmpir_state_e state_d;
  cmpir_evt_t   irqEn_q;
  cmpir_evt_t   irqEn_d;
  cmpir_evt_t   evtFlag_q;
  cmpir_evt_t   evtFlag_d;
  cmpir_evt_t   edgeEvt;
  cmpir_evt_t   newEvt;
  logic         result_q;
  logic [1:0]   enable_q;
  logic [7:0]   startCnt_q;
  logic [31:0]  rdata_q;
  logic [31:0]  rdMux;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  wire hitDirect = bus.addr == `CMPIR_OFS_IRQ_DIRECT;
  wire hitSet    = bus.addr == `CMPIR_OFS_IRQ_SET;
  wire hitClear  = bus.addr == `CMPIR_OFS_IRQ_CLEAR;
  wire hitResult = bus.addr == `CMPIR_OFS_RESULT;
  wire hitEnable = bus.addr == `CMPIR_OFS_ENABLE;
  wire hitStatus = bus.addr == `CMPIR_OFS_EVT_STATUS;
  wire hitTask   = bus.addr == `CMPIR_OFS_TASK;

  wire wrSet    = bus.wr && hitSet;
  wire wrClear  = bus.wr && hitClear;
  wire wrDirect = bus.wr && hitDirect;
  wire wrStatus = bus.wr && hitStatus;
  wire wrEnable = bus.wr && hitEnable;
  wire wrTask   = bus.wr && hitTask;

  wire taskStart  = wrTask && bus.wdata[`CMPIR_BIT_TASK_START];
  wire taskStop   = wrTask && bus.wdata[`CMPIR_BIT_TASK_STOP];
  wire taskSample = (wrTask && bus.wdata[`CMPIR_BIT_TASK_SAMPLE]) || sampleTrig;
  wire isRunning  = state_q == CMPIR_RUN;
  wire compOn     = enable_q != `CMPIR_RST_ENABLE;
  wire readyPulse = state_q == CMPIR_START && startCnt_q == `CMPIR_READY_CYCLES;

  cmpir_edge u_edge (
    .clock    (clock),
    .nrst     (nrst),
    .running  (isRunning),
    .compOut  (compOut),
    .evtPulse (edgeEvt)
  );

  always_comb begin
    newEvt = edgeEvt;
    newEvt[`CMPIR_BIT_READY] = readyPulse;
  end

  always_comb begin
    irqEn_d = irqEn_q;
    if (wrDirect) begin
      irqEn_d = bus.wdata[3:0];
    end
    if (wrSet) begin
      irqEn_d = irqEn_q | bus.wdata[3:0];
    end
    if (wrClear) begin
      irqEn_d = irqEn_q & ~bus.wdata[3:0];
    end
  end

  // Set wins over write-one clear
  always_comb begin
    evtFlag_d = evtFlag_q;
    if (wrStatus) begin
      evtFlag_d = evtFlag_q & ~bus.wdata[3:0];
    end
    evtFlag_d = evtFlag_d | newEvt;
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      CMPIR_IDLE: begin
        if (taskStart && compOn) begin
          state_d = CMPIR_START;
        end
      end
      CMPIR_START: begin
        if (taskStop || !compOn) begin
          state_d = CMPIR_IDLE;
        end else if (readyPulse) begin
          state_d = CMPIR_RUN;
        end
      end
      CMPIR_RUN: begin
        if (taskStop || !compOn) begin
          state_d = CMPIR_IDLE;
        end
      end
      default: begin
        state_d = CMPIR_IDLE;
      end
    endcase
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitDirect || hitSet || hitClear) begin
      rdMux[3:0] = irqEn_q;
    end else if (hitResult) begin
      rdMux[0] = result_q;
    end else if (hitEnable) begin
      rdMux[1:0] = enable_q;
    end else if (hitStatus) begin
      rdMux[3:0] = evtFlag_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q   <= CMPIR_IDLE;
      irqEn_q   <= `CMPIR_RST_IRQ;
      evtFlag_q <= `CMPIR_RST_IRQ;
      enable_q  <= `CMPIR_RST_ENABLE;
    end else begin
      state_q   <= state_d;
      irqEn_q   <= irqEn_d;
      evtFlag_q <= evtFlag_d;
      if (wrEnable) begin
        enable_q <= bus.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      startCnt_q <= 8'h00;
    end else if (state_q == CMPIR_START) begin
      startCnt_q <= startCnt_q + 8'h01;
    end else begin
      startCnt_q <= 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      result_q <= `CMPIR_RST_RESULT;
    end else if (taskSample && isRunning) begin
      result_q <= compOut;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata_q <= rdMux;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata       = rdata_q;
  assign compPowered = state_q != CMPIR_IDLE;
  assign irq         = |(evtFlag_q & irqEn_q);
endmodule : cmpir_regs

// ==== verif/cmpir_regs_assertions.sv ====
// Port checker of the comparator interrupt bank
`timescale 1ns/1ns
module cmpir_regs_chk (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        compOut,
  input wire logic        sampleTrig,
  input wire logic        compPowered,
  input wire logic        irq
);
  wire rdSet = rd && addr == 12'h304;
  wire rdClr = rd && addr == 12'h308;
  wire rdRes = rd && addr == 12'h400;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_read_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000) else $error("rdata");
  a_upper_zero: assert property ($past(rdSet) |-> rdata[31:4] == 28'h000_0000) else $error("upper");
  a_set_clr: assert property (rdSet ##1 rdClr |=> rdata == $past(rdata)) else $error("views");
  a_res_width: assert property ($past(rdRes) |-> rdata[31:1] == 31'h0000_0000) else $error("width");
  a_res_hold: assert property (!$past(sampleTrig) && !$past(wr) && rdRes && !sampleTrig && !wr
    ##1 rdRes && !sampleTrig |=> rdata == $past(rdata)) else $error("hold");
  a_set_all: assert property (wr && addr == 12'h304 && wdata[3:0] == 4'hF ##1 rdSet
    |=> rdata[3:0] == 4'hF) else $error("set");
  a_clr_all: assert property (wr && addr == 12'h308 && wdata[3:0] == 4'hF ##1 rdClr
    |=> rdata[3:0] == 4'h0) else $error("clear");
  a_irq_off: assert property ($past(rdSet) && rdata[3:0] == 4'h0 |-> !irq) else $error("irq");
  c_sample: cover property (rdRes ##1 rdata[0]);
  c_irq: cover property ($rose(irq));
  c_run: cover property ($rose(compPowered));
endmodule : cmpir_regs_chk

// ==== verif/cmpir_regs_tb.sv ====
// Self-checking bench of the comparator interrupt bank
`timescale 1ns/1ns
module cmpir_regs_tb;
  logic        clock = 0, nrst = 0, wr = 0, rd = 0, compOut = 0, sampleTrig = 0, rdSeen_q = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, lf = 32'h3858, rdata, eq[$];
  logic [3:0]  mEn = 0;
  logic        compPowered, irq;
  int          fail_count = 0, samples_checked = 0, i;
  always #20 clock = ~clock;
  cmpir_regs i_cmpir_regs (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .compOut, .sampleTrig, .compPowered, .irq);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_lvl(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t level got %b exp %b", $time, g, e);
    end
  endtask : chk_lvl
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : bus
  task automatic wt(input logic [11:0] a, input logic [31:0] d);
    if (a == 12'h300) mEn = d[3:0];
    if (a == 12'h304) mEn = mEn | d[3:0];
    if (a == 12'h308) mEn = mEn & ~d[3:0];
    bus(1, 0, a, d);
  endtask : wt
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    eq.push_back(e);
    bus(0, 1, a, 0);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) bus(0, 0, 0, 0);
  endtask : idle
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  always @(posedge clock) rdSeen_q <= rd;
  always @(negedge clock) if (rdSeen_q) chk(rdata, eq.pop_front());
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1;
    rdc(12'h304, 0);
    rdc(12'h400, 0);
    rdc(12'h7FC, 0);
    #1 chk_lvl(compPowered, 1'b0);
    wt(12'h304, 32'h0000_000F);
    rdc(12'h304, 32'h0000_000F);
    rdc(12'h308, 32'h0000_000F);
    wt(12'h308, 32'h0000_000F);
    rdc(12'h308, 0);
    for (i = 0; i < 40; i++) begin
      lf = nx(lf);
      wt(lf[4] ? 12'h304 : 12'h308, lf);
      rdc(lf[5] ? 12'h304 : 12'h308, {28'h000_0000, mEn});
    end
    wt(12'h308, 32'h0000_000F);
    wt(12'h300, 32'h0000_0005);
    rdc(12'h304, {28'h000_0000, mEn});
    wt(12'h300, 32'h0000_0000);
    rdc(12'h300, {28'h000_0000, mEn});
    wt(12'h500, 32'h0000_0001);
    wt(12'h604, 32'h0000_0002);
    idle(90);
    #1 chk_lvl(compPowered, 1'b1);
    rdc(12'h600, 32'h0000_0001);
    wt(12'h304, 32'h0000_0001);
    idle(1);
    #1 chk_lvl(irq, 1'b1);
    wt(12'h308, 32'h0000_0001);
    idle(1);
    #1 chk_lvl(irq, 1'b0);
    wt(12'h304, 32'h0000_0001);
    wt(12'h600, 32'h0000_0001);
    idle(1);
    #1 chk_lvl(irq, 1'b0);
    idle(1);
    compOut <= 1;
    idle(4);
    rdc(12'h600, 32'h0000_000C);
    sampleTrig <= 1;
    idle(1);
    sampleTrig <= 0;
    idle(2);
    rdc(12'h400, 1);
    compOut <= 0;
    idle(4);
    rdc(12'h600, 32'h0000_000E);
    sampleTrig <= 1;
    idle(1);
    sampleTrig <= 0;
    wt(12'h400, 32'hFFFF_FFFF);
    idle(2);
    rdc(12'h400, 0);
    wt(12'h304, 32'h0000_0002);
    idle(1);
    #1 chk_lvl(irq, 1'b1);
    compOut <= 1;
    rdc(12'h400, 0);
    rdc(12'h400, 0);
    wt(12'h604, 32'h0000_0001);
    rdc(12'h400, 1);
    wt(12'h604, 32'h0000_0004);
    idle(1);
    #1 chk_lvl(compPowered, 1'b0);
    compOut <= 0;
    sampleTrig <= 1;
    idle(1);
    sampleTrig <= 0;
    rdc(12'h400, 1);
    idle(2);
    nrst <= 0;
    idle(3);
    nrst <= 1;
    mEn = 4'h0;
    rdc(12'h304, 0);
    rdc(12'h400, 0);
    rdc(12'h600, 0);
    idle(2);
    results();
  end
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule : cmpir_regs_tb
bind cmpir_regs cmpir_regs_chk i_cmpir_regs_chk (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .compOut,
  .sampleTrig, .compPowered, .irq);
